// file: design/lpdc_core.sv
// pulse counting dimming control with automatic pump mode selection
// assumes analog comparators for undercurrent and led presence on pins
// Summary of operation
// - four-bit brightness step, sixteenth step gives zero current, drive off
// - seventeenth pulse wraps the step back to the first, full current
// - each step lowers current by one fifteenth of maximum
// - channels of an input carry no current while that input is low
// - each pulse input keeps its own brightness step
// - both inputs low for the idle time enters power save
// - entering power save resets both brightness steps
// - first rising edge on either input leaves power save
// - input already high at power up starts after the reset interval
// - group selects map channels between the two pulse inputs
// - only three output states: standby, pass-through, boost
// - pump mode comes from internal detection only
// - startup runs boost for a fixed interval to find connected leds
// - undercurrent on any connected, driven channel switches to boost
// - presence change flags error; idle channel never forces boost
// - periodic mode reset forces pass-through every 1.4 seconds
// - after mode reset, hold pass-through and ignore undercurrent
//
// Chosen here: the placing of the registers and the APB slave port.
module lpdc_core
  import lpdc_pkg::*;
#(
  parameter logic [CNT_W-1:0] IDLE_CYCLES = CNT_W'(IDLE_CYC),
  parameter logic [CNT_W-1:0] PERIOD_CYCLES = CNT_W'(PERIOD_CYC),
  parameter logic [CNT_W-1:0] HOLD_CYCLES = CNT_W'(HOLD_CYC),
  parameter logic [CNT_W-1:0] SS_CYCLES = CNT_W'(SS_CYC),
  parameter logic [CNT_W-1:0] BOOST_CYCLES = CNT_W'(BOOST_CYC)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pulse and group pins
  input wire logic pulse_input_a,
  input wire logic pulse_input_b,
  input wire logic group_choice_a,
  input wire logic group_choice_b,
  // analog detector levels, one per sink
  input wire logic [NCH-1:0] undercurrent,
  input wire logic [NCH-1:0] led_present,
  // drive outputs
  output logic [NCH-1:0] sink_enable,
  output logic [4*NCH-1:0] led_drive_current,
  output logic [1:0] pump_output_mode,
  output logic active,
  output logic conn_error
);

  localparam logic [CNT_W-1:0] POR_CYCLES = CNT_W'(POR_CYC);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  lpdc_pins_if pins ();
  lpdc_top_s q;
  lpdc_top_s d;

  lpdc_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw({led_present, undercurrent, group_choice_a, group_choice_b,
          pulse_input_b, pulse_input_a}),
    .pins(pins.src)
  );

  logic any_high;
  logic any_rise;
  logic [NCH-1:0] on_b;
  logic [NCH-1:0] uc_live;
  logic mode_reset;
  logic apb_access;
  logic apb_setup;
  logic clr_err;

  assign any_high = |pins.pulse_lvl;
  assign any_rise = |pins.pulse_rise;
  assign mode_reset = (q.st == ST_RUN) && (q.per == PERIOD_CYCLES - ONE);
  assign uc_live = pins.uc & q.present & q.sink_on;
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable && q.pready;
  assign clr_err = apb_access && pwrite && (paddr == CTRL_OFS) &&
                   pwdata[CLR_ERR_BIT];

  // channels taken over by input b, counted from sink six downward
  always_comb begin
    case (pins.group_sel)
      2'b00: on_b = 6'b00_0000;
      2'b01: on_b = 6'b10_0000;
      2'b10: on_b = 6'b11_0000;
      2'b11: on_b = 6'b11_1000;
      default: on_b = 6'b00_0000;
    endcase
  end

  always_comb begin
    d = q;
    d.tmr = q.tmr + ONE;
    d.idle = any_high ? '0 : q.idle + ONE;
    case (q.st)
      ST_POR: begin
        // pins are ignored until the reset interval has run out
        if (q.tmr >= POR_CYCLES - ONE) begin
          d.tmr = '0;
          d.st = any_high ? ST_START : ST_SAVE;
          d.boost = any_high;
        end
      end
      ST_SAVE: begin
        d.tmr = '0;
        d.step_a = STEP_FIRST;
        d.step_b = STEP_FIRST;
        if (any_rise) begin
          d.st = ST_START;
          d.idle = '0;
          d.boost = 1'b1;
        end
      end
      ST_START: begin
        d.boost = 1'b1;
        if (q.tmr == BOOST_CYCLES - ONE) begin
          d.present = pins.present;
        end
        if (q.tmr >= SS_CYCLES - ONE) begin
          d.st = ST_RUN;
          d.boost = 1'b0;
          d.per = '0;
        end
      end
      ST_RUN: begin
        d.per = mode_reset ? '0 : q.per + ONE;
        if (q.hold != '0) begin
          d.hold = q.hold - ONE;
        end
        if (mode_reset) begin
          d.boost = 1'b0;
          // counting down to zero keeps the window within its length
          d.hold = HOLD_CYCLES - ONE;
        end else if (q.hold == '0 && |uc_live) begin
          d.boost = 1'b1;
        end
      end
      default: d.st = ST_POR;
    endcase
    // steps count in start and run; the waking edge itself is step one
    if (q.st == ST_START || q.st == ST_RUN) begin
      if (pins.pulse_rise[0]) begin
        d.step_a = q.step_a + 4'h1;
      end
      if (pins.pulse_rise[1]) begin
        d.step_b = q.step_b + 4'h1;
      end
      if (q.idle >= IDLE_CYCLES - ONE && !any_high) begin
        d.st = ST_SAVE;
        d.step_a = STEP_FIRST;
        d.step_b = STEP_FIRST;
        d.boost = 1'b0;
        d.hold = '0;
      end
    end
    // connection changes after startup are latched until cleared
    if (clr_err) begin
      d.conn_err = 1'b0;
    end
    if (q.st == ST_RUN && pins.present != q.present) begin
      d.conn_err = 1'b1;
    end
    // only three output states exist; mode is never set from outside
    case (d.st)
      ST_START, ST_RUN: d.pump = d.boost ? PUMP_BOOST : PUMP_PASS;
      default: d.pump = PUMP_OFF;
    endcase
    d.act = (d.pump != PUMP_OFF);
    for (int i = 0; i < NCH; i++) begin
      d.sink_on[i] = 1'b0;
      d.sink_lvl[4*i +: 4] = 4'h0;
      if (q.st == ST_RUN) begin
        if (on_b[i]) begin
          d.sink_lvl[4*i +: 4] = LEVEL_MAX - q.step_b;
          d.sink_on[i] = pins.pulse_lvl[1] &&
                         q.step_b != STEP_LAST;
        end else begin
          d.sink_lvl[4*i +: 4] = LEVEL_MAX - q.step_a;
          d.sink_on[i] = pins.pulse_lvl[0] &&
                         q.step_a != STEP_LAST;
        end
      end
    end
    // no wait state: ready rises in the first access cycle
    d.pready = apb_setup;
    d.pslverr = 1'b0;
    if (apb_setup) begin
      d.prdata = RESET_WORD;
      case (paddr)
        STATUS_OFS: d.prdata = {19'h0_0000, q.hold != '0, q.step_b,
                                q.step_a, 1'b0, q.conn_err, q.pump};
        CTRL_OFS: d.prdata = RESET_WORD;
        default: d.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign sink_enable = q.sink_on;
  assign led_drive_current = q.sink_lvl;
  assign pump_output_mode = q.pump;
  assign active = q.act;
  assign conn_error = q.conn_err;

  chk_step_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    (q.st == ST_RUN && pins.pulse_rise[0] && q.step_a == STEP_LAST &&
     !(q.idle >= IDLE_CYCLES - ONE && !any_high))
    |=> q.step_a == STEP_FIRST)
    else $error("step a did not wrap to first step");

  chk_level_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    (q.st == ST_RUN && !on_b[0] && $stable(q.step_a))
    |=> led_drive_current[3:0] == 4'hf - $past(q.step_a))
    else $error("sink one level does not follow step a");

  chk_low_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pins.pulse_lvl[0] && !on_b[0] |=> !sink_enable[0])
    else $error("sink one driven while input a low");

  chk_save_steps: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.st == ST_SAVE |=> q.step_a == STEP_FIRST && q.step_b == STEP_FIRST)
    else $error("steps not cleared in power save");

  chk_wake_edge: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.st == ST_SAVE && any_rise |=> q.st == ST_START ##1 active)
    else $error("no wake on first rising edge");

  chk_idle_save: assert property (
    @(posedge pclk) disable iff (!presetn)
    (q.st == ST_RUN && !any_high && q.idle == IDLE_CYCLES - ONE)
    |=> q.st == ST_SAVE ##1 !active && sink_enable == '0)
    else $error("idle timeout did not enter power save");

  chk_idle_restart: assert property (
    @(posedge pclk) disable iff (!presetn)
    any_high |=> q.idle == '0)
    else $error("idle timer not restarted by high input");

  chk_start_boost: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.st == ST_START && q.tmr < SS_CYCLES - ONE |=> q.boost)
    else $error("startup not in boost");

  chk_reset_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    mode_reset && !(q.idle >= IDLE_CYCLES - ONE && !any_high)
    |=> !q.boost [*8])
    else $error("boost during mode hold window");

  chk_boost_uc: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.st == ST_RUN && !mode_reset && q.hold == '0 && |uc_live &&
    !(q.idle >= IDLE_CYCLES - ONE && !any_high)
    |=> pump_output_mode == PUMP_BOOST)
    else $error("undercurrent did not raise boost");

  chk_por_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.st == ST_POR && q.tmr < POR_CYCLES - ONE |=> q.st == ST_POR && !active)
    else $error("left power-on wait early");

  chk_last_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.step_a == STEP_LAST && !on_b[0] |=> !sink_enable[0])
    else $error("sink one driven at the last step");

  chk_group_split: assert property (
    @(posedge pclk) disable iff (!presetn)
    pins.group_sel == 2'b11 && !pins.pulse_lvl[1]
    |=> sink_enable[5:3] == 3'b000)
    else $error("upper sinks driven with input b low");

  chk_uc_ignored: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.st == ST_RUN && !q.boost && !mode_reset &&
    (pins.uc & q.present & q.sink_on) == '0 |=> !q.boost)
    else $error("boost without undercurrent on a driven sink");

  chk_conn_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.st == ST_RUN && pins.present != q.present |=> conn_error)
    else $error("presence change not flagged");

endmodule

// file: design/lpdc_pin_sync.sv
// two-stage synchroniser for every asynchronous pin and edge finder
// assumes raw pins come from outside the clock domain
module lpdc_pin_sync
  import lpdc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins: pulses, group choice, undercurrent, presence
  input wire logic [NSYNC-1:0] raw,
  // synchronised view
  lpdc_pins_if.src pins
);

  lpdc_sync_s s_q;
  lpdc_sync_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = raw;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync[1:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // edges are taken from the second stage only
  assign pins.pulse_lvl = s_q.sync[1:0];
  assign pins.pulse_rise = s_q.sync[1:0] & ~s_q.prev;
  assign pins.group_sel = s_q.sync[3:2];
  assign pins.uc = s_q.sync[9:4];
  assign pins.present = s_q.sync[15:10];

endmodule

// file: design/lpdc_pins_if.sv
// synchronised pin levels passed from the input stage to the core
// assumes both ends run on the same clock
interface lpdc_pins_if;
  import lpdc_pkg::*;
  logic [1:0] pulse_lvl;
  logic [1:0] pulse_rise;
  logic [1:0] group_sel;
  logic [NCH-1:0] uc;
  logic [NCH-1:0] present;
  modport src (output pulse_lvl, pulse_rise, group_sel, uc, present);
  modport dst (input pulse_lvl, pulse_rise, group_sel, uc, present);
endinterface

// file: design/lpdc_pkg.sv
// constants and state types of the led pulse dimming control block
// assumes a single 25 MHz clock and an active-low asynchronous reset
package lpdc_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int CNT_W = 26;
  localparam int NCH = 6;
  localparam int NSYNC = 16;

  // times in their own unit, counts derived from the clock period
  localparam int POR_NS = 50_000;
  localparam int IDLE_NS = 1_630_000;
  localparam int HOLD_MIN_NS = 85_000;
  localparam int HOLD_MAX_NS = 200_000;
  localparam int PERIOD_MS = 1400;
  localparam int SS_NS = 1_300_000;
  localparam int BOOST_NS = 500_000;

  localparam int POR_CYC = (POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_CYC = IDLE_NS / CLK_PERIOD_NS;
  localparam int HOLD_MIN_CYC =
    (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = HOLD_MAX_NS / CLK_PERIOD_NS;
  localparam int PERIOD_CYC = PERIOD_MS * (1_000_000 / CLK_PERIOD_NS);
  localparam int SS_CYC = SS_NS / CLK_PERIOD_NS;
  localparam int BOOST_CYC = BOOST_NS / CLK_PERIOD_NS;

  // register map
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam int CLR_ERR_BIT = 0;

  // brightness step held as data minus one
  localparam logic [3:0] STEP_FIRST = 4'h0;
  localparam logic [3:0] STEP_LAST = 4'hf;
  localparam logic [3:0] LEVEL_MAX = 4'hf;

  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_SAVE = 2'b01,
    ST_START = 2'b11,
    ST_RUN = 2'b10
  } lpdc_state_e;

  typedef enum logic [1:0] {
    PUMP_OFF = 2'b00,
    PUMP_PASS = 2'b01,
    PUMP_BOOST = 2'b10
  } lpdc_pump_e;

  typedef struct packed {
    logic [NSYNC-1:0] meta;
    logic [NSYNC-1:0] sync;
    logic [1:0] prev;
  } lpdc_sync_s;

  typedef struct packed {
    lpdc_state_e st;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] idle;
    logic [CNT_W-1:0] per;
    logic [CNT_W-1:0] hold;
    logic [3:0] step_a;
    logic [3:0] step_b;
    logic boost;
    lpdc_pump_e pump;
    logic act;
    logic [NCH-1:0] present;
    logic conn_err;
    logic [NCH-1:0] sink_on;
    logic [4*NCH-1:0] sink_lvl;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lpdc_top_s;

endpackage

// file: dv/lpdc_host_model.sv
// host side model: sends counted pulses on one of the two pulse pins
// assumes the bench holds go for one cycle; pins start low and stay high after a burst until drop
module lpdc_host_model (
  // clock
  input wire logic pclk,
  // command from the bench
  input wire logic go,
  input wire logic chan,
  input wire logic [5:0] count,
  input wire logic drop,
  input wire logic tie,
  // pins and status
  output logic pulse_input_a,
  output logic pulse_input_b,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] lvl_q = 2'b00;
  logic c_q = 1'b0;
  int n_q = 0;
  int ph_q = 0;
  always @(posedge pclk) begin
    if (drop) begin
      lvl_q <= 2'b00;
      n_q <= 0;
    end else if (go) begin
      n_q <= int'(count);
      c_q <= chan;
      ph_q <= 0;
    end else if (n_q != 0) begin
      // each level held four cycles, above the three-cycle minimum
      lvl_q[c_q] <= (ph_q >= 4);
      ph_q <= (ph_q == 7) ? 0 : ph_q + 1;
      if (ph_q == 7) begin
        n_q <= n_q - 1;
      end
    end
  end
  assign pulse_input_a = lvl_q[0];
  assign pulse_input_b = tie ? lvl_q[0] : lvl_q[1];
  assign busy = (n_q != 0);
endmodule

// file: dv/tb_led_pulse_dimming_control.sv
// self-checking bench of the pulse dimming core against a step model
// assumes shortened timing parameters; power-on wait stays 1250 cycles
module tb_led_pulse_dimming_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, pa, pb, act, cerr;
  logic ga = 1'b0, gb = 1'b0, go = 1'b0, chan = 1'b0;
  logic drop = 1'b0, tie = 1'b1;
  logic [5:0] count = 6'h00, uc = 6'h00, pres = 6'h3f, sen;
  logic [23:0] cur;
  logic [1:0] pmode;
  logic busy;
  int fail_count = 0, n_compared = 0, st_a = 0, st_b = 0, n = 0;

  lpdc_core #(.IDLE_CYCLES(64), .PERIOD_CYCLES(400), .HOLD_CYCLES(20),
    .SS_CYCLES(100), .BOOST_CYCLES(40)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_input_a(pa), .pulse_input_b(pb),
    .group_choice_a(ga), .group_choice_b(gb), .undercurrent(uc),
    .led_present(pres), .sink_enable(sen), .led_drive_current(cur),
    .pump_output_mode(pmode), .active(act), .conn_error(cerr));
  lpdc_host_model u_host (.pclk(pclk), .go(go), .chan(chan),
    .count(count), .drop(drop), .tie(tie), .pulse_input_a(pa),
    .pulse_input_b(pb), .busy(busy));

  initial begin
    forever #20 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never drives psel twice at once
    @(posedge pclk);
    if (k >= 50) begin
      cmp("pready", 1, pready);
      end_sim();
    end
  endtask

  task automatic wait_pump(input logic [1:0] e, input int lim);
    int k;
    k = 0;
    while (pmode !== e && k < lim) begin
      @(posedge pclk);
      k++;
    end
    cmp("pump_output_mode", e, pmode);
    if (pmode !== e) end_sim();
  endtask

  task automatic pulses(input logic ch, input logic [5:0] n);
    int k;
    k = 0;
    chan <= ch;
    count <= n;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy && k < 600) begin
      @(posedge pclk);
      k++;
    end
    if (busy) begin
      cmp("host_busy", 0, busy);
      end_sim();
    end
    tick(8);
  endtask

  // drive current is only compared on sinks whose pin is high
  task automatic check_drive();
    logic [5:0] en;
    logic [23:0] ex, msk;
    logic p;
    int s;
    for (int i = 0; i < 6; i++) begin
      s = (i >= 6 - int'({ga, gb})) ? st_b : st_a;
      p = (i >= 6 - int'({ga, gb})) ? pb : pa;
      en[i] = p && s != 15;
      ex[4*i +: 4] = 4'(15 - s);
      msk[4*i +: 4] = {4{p}};
    end
    cmp("sink_enable", en, sen);
    cmp("led_drive_current", ex & msk, cur & msk);
  endtask

  initial begin
    void'($urandom(44675));
    tick(5);
    presetn <= 1'b1;
    tick(2);
    cmp("pump_output_mode", 0, pmode);
    apb(0, 8'h00, 0);
    cmp("status", 0, rd);
    apb(0, 8'h08, 0);
    cmp("pslverr", 1, er);
    tick(1300);
    cmp("active", 0, act);
    $display("test reset done");
    pulses(0, 1);
    cmp("pump_output_mode", 2, pmode);
    tick(120);
    cmp("pump_output_mode", 1, pmode);
    check_drive();
    $display("test startup done");
    for (int k = 0; k < 17; k++) begin
      pulses(0, 1);
      st_a = (st_a + 1) % 16;
      st_b = st_a;
      check_drive();
    end
    $display("test steps done");
    {ga, gb} <= 2'b11;
    tie <= 1'b0;
    tick(8);
    check_drive();
    // six-zero grouping comes last, with input b tied to input a
    for (int g = 1; g <= 4; g++) begin
      {ga, gb} <= 2'(g % 4);
      tie <= (g == 4);
      n = 1 + $urandom % 3;
      pulses(1, 6'(n));
      st_b = (g == 4) ? st_b : (st_b + n) % 16;
      n = 1 + $urandom % 3;
      pulses(0, 6'(n));
      st_a = (st_a + n) % 16;
      st_b = (g == 4) ? (st_b + n) % 16 : st_b;
      check_drive();
    end
    $display("test groups done");
    // a sink at the last step does not regulate, so keep both groups off it
    while (st_a == 15 || st_b == 15) begin
      pulses(0, 1);
      st_a = (st_a + 1) % 16;
      st_b = (st_b + 1) % 16;
    end
    uc <= 6'h01 << ($urandom % 6);
    wait_pump(2'b10, 60);
    wait_pump(2'b01, 600);
    for (int i = 0; i < 15; i++) begin
      @(posedge pclk);
      cmp("hold", 1, pmode);
    end
    wait_pump(2'b10, 40);
    uc <= 6'h00;
    $display("test pump mode done");
    pres <= 6'h1f;
    tick(8);
    cmp("conn_error", 1, cerr);
    apb(0, 8'h00, 0);
    cmp("status_err", 1, rd[2]);
    pres <= 6'h3f;
    tick(8);
    apb(1, 8'h04, 32'h0000_0001);
    tick(2);
    cmp("conn_error", 0, cerr);
    wait_pump(2'b01, 600);
    while (st_a != 15) begin
      pulses(0, 1);
      st_a = (st_a + 1) % 16;
      st_b = (st_b + 1) % 16;
    end
    uc <= 6'h01;
    tick(40);
    cmp("pump_output_mode", 1, pmode);
    check_drive();
    uc <= 6'h00;
    $display("test connection done");
    drop <= 1'b1;
    @(posedge pclk);
    drop <= 1'b0;
    tick(40);
    cmp("active", 1, act);
    wait_pump(2'b00, 100);
    cmp("sinks_off", 0, sen);
    pulses(0, 1);
    st_a = 0;
    st_b = 0;
    tick(120);
    check_drive();
    apb(0, 8'h00, 0);
    cmp("status_steps", 0, rd[11:4]);
    $display("test power save done");
    // second reset with input a already high: start only after the wait
    presetn <= 1'b0;
    tick(2);
    cmp("active", 0, act);
    presetn <= 1'b1;
    tick(1200);
    cmp("active", 0, act);
    tick(60);
    cmp("pump_output_mode", 2, pmode);
    $display("test restart done");
    end_sim();
  end
endmodule
